/* File: common/ccf_map.vh */
`ifndef CCF_MAP_VH
`define CCF_MAP_VH
// Opcode fields of the 14-bit instruction word
`define CCF_CALL_OP_MSB 13
`define CCF_CALL_OP_LSB 11
`define CCF_CALL_OP 3'h4
`define CCF_CLEAR_FILE_OP_OP_MSB 13
`define CCF_CLEAR_FILE_OP_OP_LSB 7
`define CCF_CLEAR_FILE_OP_OP 7'h03
`define CCF_TARGET_MSB 10
`define CCF_FADDR_MSB 6
// Upper-PC latch bits copied into pc[12:11]
`define CCF_LATCH_HI 4
`define CCF_LATCH_LO 3
// Zero flag position in the status byte
`define CCF_ZERO_BIT 2
// Reset values
`define CCF_PC_RST 13'h0000
`define CCF_DATA_RST 8'h00
`define CCF_ADDR_RST 7'h00
`define CCF_CLEAR_VAL 8'h00
`endif

/* File: hw/ccf_exec.v */
`timescale 1ns/1ps
`include "ccf_map.vh"
module ccf_exec #(
  parameter PC_W = 13,
  parameter INSN_W = 14
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst_n,
  // Instruction stream, one word per instruction cycle
  input wire insn_valid,
  input wire [INSN_W-1:0] insn,
  input wire [7:0] pc_upper_latch,
  input wire [7:0] status_in,
  // Program counter and stack push
  output reg [PC_W-1:0] pc_q,
  output reg push_q,
  output reg [PC_W-1:0] stack_top_q,
  // Data register write and status write
  output reg file_we_q,
  output reg [6:0] file_addr_q,
  output reg [7:0] file_data_q,
  output reg status_we_q,
  output reg [7:0] status_out_q,
  // Idle second cycle of a call
  output reg busy_q
);

  // One-hot execution states
  localparam ST_RUN = 2'h1;
  localparam ST_IDLE = 2'h2;

  // Registered state and next values
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [PC_W-1:0] pc_d;
  reg push_d;
  reg [PC_W-1:0] stack_top_d;
  reg file_we_d;
  reg [6:0] file_addr_d;
  reg [7:0] file_data_d;
  reg status_we_d;
  reg [7:0] status_out_d;
  reg busy_d;

  // Opcode classes of the presented word
  wire is_call;
  wire is_clear_file_op;
  wire run_state;
  wire take_call;
  wire take_clear_file_op;
  wire take_other;

  // Fields lifted from the word and the latch
  wire [`CCF_TARGET_MSB:0] call_target;
  wire [1:0] latch_bits;
  wire [`CCF_FADDR_MSB:0] clear_addr;
  wire [PC_W-1:0] pc_next;
  wire [7:0] status_set;

  assign is_call = (insn[`CCF_CALL_OP_MSB:`CCF_CALL_OP_LSB] == `CCF_CALL_OP);
  assign is_clear_file_op = (insn[`CCF_CLEAR_FILE_OP_OP_MSB:`CCF_CLEAR_FILE_OP_OP_LSB] == `CCF_CLEAR_FILE_OP_OP);
  assign run_state = (state_q == ST_RUN);

  // A word offered in the idle cycle of a call is dropped, never run
  assign take_call = insn_valid && run_state && is_call;
  assign take_clear_file_op = insn_valid && run_state && is_clear_file_op;
  assign take_other = insn_valid && run_state && !is_call && !is_clear_file_op;

  assign call_target = insn[`CCF_TARGET_MSB:0];
  assign latch_bits = pc_upper_latch[`CCF_LATCH_HI:`CCF_LATCH_LO];
  assign clear_addr = insn[`CCF_FADDR_MSB:0];
  // Wraps at the top of program memory, as the counter does
  assign pc_next = pc_q + {{(PC_W-1){1'b0}}, 1'b1};

  // Zero flag forced high, every other status bit passed through
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_status
      if (gi == `CCF_ZERO_BIT) begin : g_zero
        assign status_set[gi] = 1'b1;
      end else begin : g_keep
        assign status_set[gi] = status_in[gi];
      end
    end
  endgenerate

  // Next state: a taken call parks the core for one idle cycle
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (take_call) begin
          state_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
        state_d = ST_RUN;
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  // Next program counter; any other valid word taken in the run state simply steps it
  always @* begin
    pc_d = pc_q;
    if (take_call) begin
      pc_d = {latch_bits, call_target};
    end else if (take_clear_file_op || take_other) begin
      pc_d = pc_next;
    end
  end

  // Return address and push strobe
  always @* begin
    push_d = 1'b0;
    stack_top_d = stack_top_q;
    if (take_call) begin
      push_d = 1'b1;
      stack_top_d = pc_next;
    end
  end

  // Data register write
  always @* begin
    file_we_d = 1'b0;
    file_addr_d = file_addr_q;
    file_data_d = file_data_q;
    if (take_clear_file_op) begin
      file_we_d = 1'b1;
      file_addr_d = clear_addr;
      file_data_d = `CCF_CLEAR_VAL;
    end
  end

  // Status write; value holds so the file can take it after the strobe
  always @* begin
    status_we_d = 1'b0;
    status_out_d = status_out_q;
    if (take_clear_file_op) begin
      status_we_d = 1'b1;
      status_out_d = status_set;
    end
  end

  // Idle marker for the second cycle of a call
  always @* begin
    busy_d = take_call;
  end

  // Registers below load only constants in reset
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // Program counter
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_q <= `CCF_PC_RST;
    end else begin
      pc_q <= pc_d;
    end
  end

  // Stack push
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      push_q <= 1'b0;
      stack_top_q <= `CCF_PC_RST;
    end else begin
      push_q <= push_d;
      stack_top_q <= stack_top_d;
    end
  end

  // Data register port
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      file_we_q <= 1'b0;
      file_addr_q <= `CCF_ADDR_RST;
      file_data_q <= `CCF_DATA_RST;
    end else begin
      file_we_q <= file_we_d;
      file_addr_q <= file_addr_d;
      file_data_q <= file_data_d;
    end
  end

  // Status port
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_we_q <= 1'b0;
      status_out_q <= `CCF_DATA_RST;
    end else begin
      status_we_q <= status_we_d;
      status_out_q <= status_out_d;
    end
  end

  // Idle marker
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= busy_d;
    end
  end

endmodule

/* File: tb/ccf_exec_monitor.sv */
`timescale 1ns/1ps
module ccf_exec_monitor(input wire sys_clk, rst_n, insn_valid, push_q, file_we_q, status_we_q, busy_q,
  input wire [13:0] insn, input wire [7:0] pc_upper_latch, status_in, file_data_q, status_out_q,
  input wire [12:0] pc_q, stack_top_q, input wire [6:0] file_addr_q);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Idle cycle of a call takes nothing
  sequence call_s; insn_valid && !busy_q && insn[13:11] == 3'h4; endsequence
  sequence clr_s; insn_valid && !busy_q && insn[13:7] == 7'h03; endsequence
  sequence idle_s; busy_q ##1 !busy_q && !push_q && !file_we_q && !status_we_q; endsequence
  push_ret_a: assert property (call_s |=> push_q && stack_top_q == $past(pc_q) + 13'h0001)
    else $error("call return address wrong");
  call_pc_a: assert property (call_s |=> pc_q == {$past(pc_upper_latch[4:3]), $past(insn[10:0])})
    else $error("call target wrong");
  call_idle_a: assert property (call_s |=> idle_s)
    else $error("call idle cycle not idle");
  idle_hold_a: assert property (call_s |=> ##1 $stable(pc_q) && $stable(stack_top_q))
    else $error("idle cycle changed state");
  clr_write_a: assert property (clr_s |=> file_we_q && file_data_q == 8'h00 && file_addr_q == $past(insn[6:0]))
    else $error("clear write wrong");
  clr_single_a: assert property (clr_s |=> !busy_q && pc_q == $past(pc_q) + 13'h0001)
    else $error("clear took more than one cycle");
  zero_flag_a: assert property (clr_s |=> status_we_q && status_out_q == ($past(status_in) | 8'h04))
    else $error("zero flag wrong");
endmodule
bind ccf_exec ccf_exec_monitor u_mon(.*);

/* File: tb/ccf_exec_test.sv */
`timescale 1ns/1ps
`define CHK(a,b) begin samples_checked++; \
  if ((a) !== (b)) begin fails++; $display("[ERR] %0t mismatch", $time); end end
module ccf_exec_test;
  reg sys_clk = 0, rst_n = 0, insn_valid = 0;
  reg [13:0] insn = 0;
  reg [7:0] pc_upper_latch = 0, status_in = 0, s = 0;
  reg [6:0] a = 0;
  wire [12:0] pc_q, stack_top_q;
  wire push_q, file_we_q, status_we_q, busy_q;
  wire [6:0] file_addr_q;
  wire [7:0] file_data_q, status_out_q;
  reg [12:0] pc = 0, stack_top = 0;
  int fails = 0, samples_checked = 0, idle = 0, c, f, i;
  ccf_exec u_ccf_exec(.*);
  initial forever #5 sys_clk = ~sys_clk;
  task stop_test;
    $display("fails=%0d samples_checked=%0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // About 512 cycles of stimulus; the limit leaves ample margin
  initial begin #30000 fails++; stop_test; end
  initial begin
    c = $urandom(50);
    repeat (12) @(posedge sys_clk);
    rst_n <= 1;
    for (i = 0; i < 500; i++) begin
      @(posedge sys_clk);
      // Model step on the word taken at this edge
      c = rst_n && insn_valid && !idle && insn[13:11] == 3'h4;
      f = rst_n && insn_valid && !idle && insn[13:7] == 7'h03;
      if (f) begin s = status_in | 8'h04; a = insn[6:0]; end
      if (c) begin stack_top = pc + 1; pc = {pc_upper_latch[4:3], insn[10:0]}; end
      else if (rst_n && insn_valid && !idle) pc++;
      idle = c;
      insn_valid <= $urandom % 4 != 0;
      insn <= $urandom % 3 == 0 ? {3'h4, 11'($urandom)} : {7'h03 ^ 7'($urandom % 2), 7'($urandom)};
      pc_upper_latch <= $urandom;
      status_in <= $urandom;
      // Mid-run reset, asserted and released on clock edges
      if (i == 250) rst_n <= 0;
      if (i == 252) rst_n <= 1;
      #1 if (!rst_n) begin pc = 0; stack_top = 0; s = 0; a = 0; c = 0; f = 0; idle = 0; end
      `CHK(pc_q, pc)
      `CHK({busy_q, push_q}, {1'(c), 1'(c)})
      `CHK(stack_top_q, stack_top)
      `CHK({file_we_q, status_we_q}, {1'(f), 1'(f)})
      `CHK({file_addr_q, file_data_q, status_out_q}, {a, 8'h00, s})
    end
    stop_test;
  end
endmodule
